// ===== twp_pkg.sv
package twp_pkg;

	// ----------------------------------------
	// bus address
	// ----------------------------------------
	localparam logic [4:0] ADDR_HI = 5'h0B;
	localparam logic RW_READ = 1'h1;
	localparam logic RW_WRITE = 1'h0;
	localparam logic ACK_LVL = 1'h0;

	// ----------------------------------------
	// instruction byte field positions
	// ----------------------------------------
	localparam int INSTR_CHAN_POS = 7;
	localparam int INSTR_MIDSCALE_POS = 6;
	localparam int INSTR_POWER_DOWN_POS = 5;
	localparam int INSTR_OUT2_POS = 4;
	localparam int INSTR_OUT1_POS = 3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCL_QTR_NS = 2500;
	localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// phases of one scl period
	// ----------------------------------------
	localparam logic [1:0] PH_LOW = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_HIGH = 2'h2;
	localparam logic [1:0] PH_FALL = 2'h3;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [8:0] RX_BYTE_NACK = 9'h1FF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_BIT = 3'b010,
		ST_STOP = 3'b011,
		ST_DONE = 3'b100
	} twp_state_t;

	typedef struct packed {
		logic chan;
		logic midscale_reset_bit;
		logic power_down_bit;
		logic logic_out_2;
		logic logic_out_1;
		logic [2:0] unused;
	} twp_instr_t;

	typedef struct packed {
		logic rw;
		logic addr_strap_pin1;
		logic addr_strap_pin0;
		twp_instr_t instr;
		logic [7:0] data;
	} twp_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic nack;
	} twp_rsp_t;

	function automatic logic [7:0] addr_byte(input logic s1, input logic s0, input logic rw);
		addr_byte = {ADDR_HI, s1, s0, rw};
	endfunction : addr_byte

endpackage : twp_pkg

// ===== twp_sync.sv
`timescale 1ns/1ps
module twp_sync #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// ----------------------------------------
	// two flops; first stage read only by second
	// ----------------------------------------
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = d;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_q <= '1;
			sync_q <= '1;
		end else if (ce) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q = sync_q;

endmodule : twp_sync

// ===== twp_host.sv
`timescale 1ns/1ps
module twp_host #(
	parameter int QTR_CYC = twp_pkg::SCL_QTR_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire twp_pkg::twp_cmd_t cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output twp_pkg::twp_rsp_t rsp,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (QTR_CYC < 1 || QTR_CYC >= (1 << twp_pkg::CNT_W)) begin : g_bad_qtr
		$error("QTR_CYC out of range");
	end

	localparam logic [twp_pkg::CNT_W-1:0] QTR_LAST = twp_pkg::CNT_W'(QTR_CYC - 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;

	twp_sync #(.WIDTH(2)) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.ce(ce),
		.d({scl_i, sda_i}),
		.q(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// ----------------------------------------
	// pin levels for a state and phase
	// ----------------------------------------
	// returns {scl released, sda released}
	function automatic logic [1:0] pin_rel(input twp_pkg::twp_state_t st, input logic [1:0] ph,
		input logic txb);
		pin_rel = 2'h3;
		unique case (st)
			twp_pkg::ST_START: begin
				pin_rel = {ph != twp_pkg::PH_FALL, ph == twp_pkg::PH_LOW};
			end
			twp_pkg::ST_BIT: begin
				pin_rel = {ph == twp_pkg::PH_RISE || ph == twp_pkg::PH_HIGH, txb};
			end
			twp_pkg::ST_STOP: begin
				pin_rel = {ph != twp_pkg::PH_LOW, ph == twp_pkg::PH_HIGH || ph == twp_pkg::PH_FALL};
			end
			default: begin
				pin_rel = 2'h3;
			end
		endcase
	endfunction : pin_rel

	// ----------------------------------------
	// quarter-period timer
	// ----------------------------------------
	twp_pkg::twp_state_t st_q;
	twp_pkg::twp_state_t st_d;
	logic [1:0] ph_q;
	logic [1:0] ph_d;
	logic scl_oe_n_q;
	logic scl_oe_n_d;
	logic sda_oe_n_q;
	logic sda_oe_n_d;
	logic [twp_pkg::CNT_W-1:0] cnt_q;
	logic [twp_pkg::CNT_W-1:0] cnt_d;
	logic stall;
	logic tick;

	// a slave holding scl low stretches the rise phase; no timeout, so a stuck bus hangs here
	assign stall = (ph_q == twp_pkg::PH_RISE) && scl_oe_n_q && !scl_s && (st_q != twp_pkg::ST_IDLE);
	assign tick = (cnt_q == '0) && !stall;

	always_comb begin
		cnt_d = cnt_q;
		if (st_q == twp_pkg::ST_IDLE || st_q == twp_pkg::ST_DONE) begin
			cnt_d = QTR_LAST;
		end else if (tick) begin
			cnt_d = QTR_LAST;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	twp_pkg::twp_cmd_t cmd_q;
	twp_pkg::twp_cmd_t cmd_d;
	logic [8:0] tx_q;
	logic [8:0] tx_d;
	logic [8:0] rx_q;
	logic [8:0] rx_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic nack_q;
	logic nack_d;
	logic [7:0] rd_q;
	logic [7:0] rd_d;
	logic cmd_ready_q;
	logic cmd_ready_d;
	logic rsp_valid_q;
	logic rsp_valid_d;
	twp_pkg::twp_rsp_t rsp_q;
	twp_pkg::twp_rsp_t rsp_d;

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		cmd_d = cmd_q;
		tx_d = tx_q;
		rx_d = rx_q;
		bit_d = bit_q;
		idx_d = idx_q;
		nack_d = nack_q;
		rd_d = rd_q;
		rsp_valid_d = 1'b0;
		rsp_d = rsp_q;
		unique case (st_q)
			twp_pkg::ST_IDLE: begin
				if (cmd_valid && cmd_ready_q) begin
					cmd_d = cmd;
					st_d = twp_pkg::ST_START;
					ph_d = twp_pkg::PH_LOW;
					// address then direction, ack slot left released
					tx_d = {twp_pkg::addr_byte(cmd.addr_strap_pin1, cmd.addr_strap_pin0, cmd.rw), 1'b1};
					idx_d = 2'h0;
					bit_d = 4'h0;
					nack_d = 1'b0;
				end
			end
			twp_pkg::ST_START: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					if (ph_q == twp_pkg::PH_FALL) begin
						st_d = twp_pkg::ST_BIT;
					end
				end
			end
			twp_pkg::ST_BIT: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					if (ph_q == twp_pkg::PH_HIGH) begin
						rx_d = {rx_q[7:0], sda_s};
					end
					if (ph_q == twp_pkg::PH_FALL) begin
						// msb first, shifted only while scl is low
						tx_d = {tx_q[7:0], 1'b1};
						bit_d = bit_q + 4'h1;
						if (bit_q == twp_pkg::ACK_BIT) begin
							bit_d = 4'h0;
							unique case (idx_q)
								2'h0: begin
									if (rx_q[0] != twp_pkg::ACK_LVL) begin
										nack_d = 1'b1;
										st_d = twp_pkg::ST_STOP;
									end else if (cmd_q.rw == twp_pkg::RW_READ) begin
										tx_d = twp_pkg::RX_BYTE_NACK;
										idx_d = 2'h1;
									end else begin
										tx_d = {cmd_q.instr, 1'b1};
										idx_d = 2'h1;
									end
								end
								2'h1: begin
									if (cmd_q.rw == twp_pkg::RW_READ) begin
										rd_d = rx_q[8:1];
										st_d = twp_pkg::ST_STOP;
									end else if (rx_q[0] != twp_pkg::ACK_LVL) begin
										nack_d = 1'b1;
										st_d = twp_pkg::ST_STOP;
									end else begin
										tx_d = {cmd_q.data, 1'b1};
										idx_d = 2'h2;
									end
								end
								default: begin
									nack_d = rx_q[0] != twp_pkg::ACK_LVL;
									st_d = twp_pkg::ST_STOP;
								end
							endcase
						end
					end
				end
			end
			twp_pkg::ST_STOP: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					if (ph_q == twp_pkg::PH_FALL) begin
						st_d = twp_pkg::ST_DONE;
					end
				end
			end
			twp_pkg::ST_DONE: begin
				rsp_valid_d = 1'b1;
				rsp_d = '{data: rd_q, nack: nack_q};
				st_d = twp_pkg::ST_IDLE;
			end
			default: begin
				st_d = twp_pkg::ST_IDLE;
			end
		endcase
		cmd_ready_d = (st_d == twp_pkg::ST_IDLE);
		{scl_oe_n_d, sda_oe_n_d} = pin_rel(st_d, ph_d, tx_d[8]);
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_q <= twp_pkg::ST_IDLE;
			ph_q <= twp_pkg::PH_LOW;
			cmd_q <= '0;
			tx_q <= '1;
			rx_q <= '0;
			bit_q <= 4'h0;
			idx_q <= 2'h0;
			nack_q <= 1'b0;
			rd_q <= 8'h00;
			cmd_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
			ph_q <= ph_d;
			cmd_q <= cmd_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			bit_q <= bit_d;
			idx_q <= idx_d;
			nack_q <= nack_d;
			rd_q <= rd_d;
			cmd_ready_q <= cmd_ready_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_q <= rsp_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= sda_oe_n_d;
		end
	end

	// open-drain: the data flop only ever holds low, the enables do the work
	logic drive_lvl_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			drive_lvl_q <= 1'b0;
		end else if (ce) begin
			drive_lvl_q <= 1'b0;
		end
	end

	assign cmd_ready = cmd_ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign scl_o = drive_lvl_q;
	assign sda_o = drive_lvl_q;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence start_done_s;
		st_q == twp_pkg::ST_START ##1 st_q == twp_pkg::ST_BIT;
	endsequence

	sequence byte_to_stop_s;
		st_q == twp_pkg::ST_BIT ##1 st_q == twp_pkg::ST_STOP;
	endsequence

	start_level_a: assert property ($fell(sda_oe_n_q) && scl_oe_n_q |-> st_q == twp_pkg::ST_START)
		else $error("sda fell with scl high outside start");
	stop_level_a: assert property ($rose(sda_oe_n_q) && scl_oe_n_q && $past(scl_oe_n_q)
		|-> st_q == twp_pkg::ST_STOP)
		else $error("sda rose with scl high outside stop");
	sda_hold_a: assert property (st_q == twp_pkg::ST_BIT && scl_oe_n_q && $past(scl_oe_n_q)
		|-> $stable(sda_oe_n_q))
		else $error("sda moved while scl high in a bit");
	addr_first_a: assert property (start_done_s |-> idx_q == 2'h0 && tx_q[8:1] ==
		twp_pkg::addr_byte(cmd_q.addr_strap_pin1, cmd_q.addr_strap_pin0, cmd_q.rw))
		else $error("first byte is not address and direction");
	instr_next_a: assert property ($changed(idx_q) && idx_q == 2'h1 && cmd_q.rw == twp_pkg::RW_WRITE
		|-> tx_q[8:1] == cmd_q.instr)
		else $error("instruction byte not after address in write");
	data_next_a: assert property ($changed(idx_q) && idx_q == 2'h2
		|-> cmd_q.rw == twp_pkg::RW_WRITE && tx_q[8:1] == cmd_q.data)
		else $error("data byte wrong or in read");
	nine_bits_a: assert property ($changed(idx_q) && idx_q != 2'h0
		|-> $past(bit_q) == twp_pkg::ACK_BIT)
		else $error("byte ended before nine pulses");
	read_nack_a: assert property (st_q == twp_pkg::ST_BIT && cmd_q.rw == twp_pkg::RW_READ &&
		idx_q == 2'h1 && bit_q == twp_pkg::ACK_BIT && ph_q == twp_pkg::PH_HIGH |-> sda_oe_n_q)
		else $error("read data byte was acknowledged");
	stop_low_a: assert property (byte_to_stop_s |-> !sda_oe_n_q && !scl_oe_n_q)
		else $error("stop did not start with sda low under scl low");
	new_xfer_a: assert property (cmd_valid && cmd_ready_q && ce |=> st_q == twp_pkg::ST_START
		##1 sda_oe_n_q [*1])
		else $error("command did not open a fresh transfer");

endmodule : twp_host

// ===== twp_dev_model.sv
`timescale 1ns/1ps
module twp_dev_model #(
	parameter logic [1:0] STRAP = 2'h2
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic slow,
	output logic scl_oe_n,
	output logic sda_oe_n,
	output logic [7:0] wiper_latch_1,
	output logic [7:0] wiper_latch_2,
	output logic [7:0] instr_q,
	output logic power_down_bit,
	output logic logic_out_1,
	output logic logic_out_2
);
	logic [7:0] sh;
	logic act;
	logic rd;
	int bc;
	int nb;
	wire logic [7:0] rdv = instr_q[7] ? wiper_latch_2 : wiper_latch_1;
	initial begin
		{wiper_latch_1, wiper_latch_2} = 16'h8080;
		{instr_q, power_down_bit, logic_out_1, logic_out_2, act, rd} = '0;
		{scl_oe_n, sda_oe_n} = 2'h3;
	end
	// ----------------------------------------
	// framing
	// ----------------------------------------
	always @(negedge sda) if (scl) begin
		bc = 0;
		nb = 0;
		act = 1;
		sda_oe_n = 1;
	end
	always @(posedge sda) if (scl) begin
		act = 0;
		sda_oe_n = 1;
	end
	always @(posedge scl) if (act) begin
		if (bc < 8) sh = {sh[6:0], sda};
		else if (rd && nb > 0 && sda) act = 0;
		bc = bc + 1;
	end
	// ----------------------------------------
	// decode and drive, only while scl low
	// ----------------------------------------
	always @(negedge scl) if (act) begin
		sda_oe_n = 1;
		if (bc == 8 && nb == 0) begin
			rd = sh[0];
			act = (sh[7:1] == {5'b01011, STRAP});
		end else if (bc == 8 && nb == 1 && !rd) begin
			instr_q = sh;
			power_down_bit = sh[5];
			{logic_out_2, logic_out_1} = sh[4:3];
			if (sh[6] && sh[7]) wiper_latch_2 = 8'h80;
			if (sh[6] && !sh[7]) wiper_latch_1 = 8'h80;
		end else if (bc == 8 && !rd && !instr_q[6]) begin
			if (instr_q[7]) wiper_latch_2 = sh;
			else wiper_latch_1 = sh;
		end
		if (bc == 8 && act && (!rd || nb == 0)) sda_oe_n = 0;
		if (bc == 9) begin
			bc = 0;
			nb = nb + 1;
		end
		if (act && rd && nb > 0 && bc < 8) sda_oe_n = rdv[7 - bc];
	end
	// slow answer: hold scl low well past the host's low quarter
	always @(negedge scl) if (slow) begin
		scl_oe_n = 0;
		#400;
		scl_oe_n = 1;
	end
endmodule : twp_dev_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, reset, cmd_valid, slow, cmd_ready, rsp_valid;
	logic scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n, pd, o1, o2;
	logic [7:0] w1, w2, ins;
	twp_pkg::twp_cmd_t cmd;
	twp_pkg::twp_rsp_t rsp, got;
	int error_cnt = 0;
	int tests_run = 0;
	// both lines are open drain with pull-up
	wire logic scl = scl_oe_n & m_scl_oe_n;
	wire logic sda = sda_oe_n & m_sda_oe_n;
	twp_host #(.QTR_CYC(4)) twp_host_inst (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp(rsp), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(),
		.sda_oe_n(sda_oe_n));
	twp_dev_model #(.STRAP(2'h2)) twp_dev_model_inst (.scl(scl), .sda(sda), .slow(slow),
		.scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n), .wiper_latch_1(w1),
		.wiper_latch_2(w2), .instr_q(ins), .power_down_bit(pd), .logic_out_1(o1),
		.logic_out_2(o2));
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", what, exp, seen);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic xfer(input logic rw, input logic [1:0] s, input logic [7:0] i,
		input logic [7:0] d);
		int n;
		@(negedge ref_clk);
		cmd = {rw, s, i, d};
		cmd_valid = 1;
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 0;
		chk("busy", 8'h00, {7'h00, cmd_ready});
		n = 0;
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		got = rsp;
		chk("done", 8'h01, {7'h00, rsp_valid});
	endtask : xfer
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("wiper1", 8'h80, w1);
		chk("wiper2", 8'h80, w2);
		chk("sda idle", 8'h01, {7'h00, sda});
	endtask : t_reset
	task automatic t_writes;
		logic [7:0] it [5] = '{8'h1F, 8'h88, 8'h30, 8'hC0, 8'h80};
		logic [7:0] dt [5] = '{8'h3C, 8'hC5, 8'h5A, 8'h11, 8'hA7};
		logic [7:0] e1 [5] = '{8'h3C, 8'h3C, 8'h5A, 8'h5A, 8'h5A};
		logic [7:0] e2 [5] = '{8'h80, 8'hC5, 8'hC5, 8'h80, 8'hA7};
		for (int k = 0; k < 5; k++) begin
			xfer(1'b0, 2'h2, it[k], dt[k]);
			chk("nack", 8'h00, {7'h00, got.nack});
			chk("instr", it[k], ins);
			chk("outs", {5'h00, it[k][5:3]}, {5'h00, pd, o2, o1});
			chk("wiper1", e1[k], w1);
			chk("wiper2", e2[k], w2);
		end
	endtask : t_writes
	task automatic t_read;
		xfer(1'b1, 2'h2, 8'h00, 8'h00);
		chk("read data", 8'hA7, got.data);
		chk("read nack", 8'h00, {7'h00, got.nack});
	endtask : t_read
	task automatic t_nack;
		xfer(1'b0, 2'h1, 8'h18, 8'h00);
		chk("nack", 8'h01, {7'h00, got.nack});
		chk("instr kept", 8'h80, ins);
		chk("wiper2 kept", 8'hA7, w2);
	endtask : t_nack
	task automatic t_slow;
		slow = 1;
		xfer(1'b0, 2'h2, 8'h00, 8'hE1);
		chk("slow wiper1", 8'hE1, w1);
		xfer(1'b1, 2'h2, 8'h00, 8'h00);
		chk("slow read", 8'hE1, got.data);
		slow = 0;
	endtask : t_slow
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end
	initial begin
		reset = 1;
		cmd_valid = 0;
		cmd = '0;
		slow = 0;
		repeat (10) @(negedge ref_clk);
		reset = 0;
		t_reset();
		t_writes();
		t_read();
		t_nack();
		t_slow();
		final_report();
	end
endmodule : tb_top
